// [rtl/rtca_pkg.sv]
package rtca_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int ADR_W  = 8;            // Byte address width
   localparam int DAT_W  = 32;           // Data width
   localparam int SEL_W  = 4;            // Byte lanes
   localparam int LANE_W = 8;            // Bits per lane

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [ADR_W-1:0] OFF_MIN_ALM_LOAD = 8'h24;
   localparam logic [ADR_W-1:0] OFF_HOUR_ALM_LOAD = 8'h28;
   localparam logic [ADR_W-1:0] OFF_DAY_ALM_LOAD = 8'h2C;
   localparam logic [ADR_W-1:0] OFF_IRQ_ENABLE   = 8'h30;
   localparam logic [ADR_W-1:0] OFF_IRQ_RAW      = 8'h34;
   localparam logic [ADR_W-1:0] OFF_IRQ_CLEAR    = 8'h38;

   // ------------------------------------------------------------
   // Field widths and reset values
   // ------------------------------------------------------------
   localparam int MIN_W  = 6;            // Minute alarm field
   localparam int HOUR_W = 5;            // Hour alarm field
   localparam int DAY_W  = 16;           // Day alarm field
   localparam int IRQ_W  = 16;           // Enable / status width
   localparam int LOAD_N = 3;            // Alarm load channels

   localparam logic [MIN_W-1:0]  MIN_RST  = 6'h00;
   localparam logic [HOUR_W-1:0] HOUR_RST = 5'h00;
   localparam logic [DAY_W-1:0]  DAY_RST  = 16'h0000;
   localparam logic [IRQ_W-1:0]  IRQ_RST  = 16'h0000;
   localparam logic [DAT_W-1:0]  DAT_ZERO = 32'h0000_0000;

   // ------------------------------------------------------------
   // Bit positions and masks
   // ------------------------------------------------------------
   localparam int LD_MIN          = 0;   // Launch channel indices
   localparam int LD_HOUR         = 1;
   localparam int LD_DAY          = 2;
   localparam int BIT_HOUR_FMT    = 5;   // Enable reg: 12h format
   localparam int BIT_RSV         = 6;   // Reserved in all three
   localparam int BIT_PM          = 4;   // Hour view: PM flag
   localparam logic [IRQ_W-1:0] EN_RW_MASK  = 16'hFFBF;
   localparam logic [IRQ_W-1:0] RAW_MASK    = 16'hFFBF;
   localparam logic [IRQ_W-1:0] CLR_MASK    = 16'hFF9F;
   localparam logic [IRQ_W-1:0] FMT_ONLY    = 16'h0020;
   localparam logic [HOUR_W-1:0] HOURS_HALF = 5'h0C;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [SEL_W-1:0] sel;
      logic [DAT_W-1:0] dat;
   } rtca_wb_req_t;

   typedef struct packed {
      logic [DAY_W-1:0]  day;
      logic [HOUR_W-1:0] hour;
      logic [MIN_W-1:0]  min;
   } rtca_alarm_t;

endpackage

// [rtl/rtca_regs.sv]
// Notes on behaviour
// - Minute alarm write launches always-on update
// - Hour alarm write launches always-on update
// - Day alarm write launches always-on update
// - Load registers read back last written value
// - Enable bits 15..8 per update source
// - Bit 7 sub-second enable, bit 6 zero
// - Bits 4..0 event enables, upper zero
// - Format bit selects 24h or 12h hour
// - Raw status shows sources before enabling
// - Update completions set raw bits 15..8
// - Writing one clears pending, zero ignored
// - Clear bits follow enable positions except format bit 5
// - Updates slow, signalled by completion events
// - Alarm values held in always-on domain
// - Every interrupt except format bit 5 can wake the system
`timescale 1ns/1ps
module rtca_regs
(
   input  wire logic                        mclk_i,       // Bus clock, 40 MHz
   input  wire logic                        rst_i,        // Async reset, high
   input  wire rtca_pkg::rtca_wb_req_t      wb_req_i,     // Wishbone request
   output logic [rtca_pkg::DAT_W-1:0]       wb_dat_o,     // Wishbone read data
   output logic                             wb_ack_o,     // Wishbone ack
   input  wire logic [rtca_pkg::IRQ_W-1:0]  aon_evt_tgl_i,// Event toggles, aon
   input  wire logic [rtca_pkg::HOUR_W-1:0] aon_hour_i,   // Hour count, aon
   output rtca_pkg::rtca_alarm_t            alarm_load_o, // Values to aon
   output logic [rtca_pkg::LOAD_N-1:0]      load_tgl_o,   // Launch toggles
   output logic [rtca_pkg::HOUR_W-1:0]      hour_view_o,  // Formatted hour
   output logic                             irq_o         // Level interrupt
);
   import rtca_pkg::*;
   localparam int ARM_N = 3;           // Edges until event sync holds real input

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   rtca_alarm_t        alarm_reg;      // Last written alarm values
   logic [LOAD_N-1:0]  load_tgl_reg;   // One toggle per launch
   logic [IRQ_W-1:0]   en_reg;         // Enables plus format bit
   logic [IRQ_W-1:0]   raw_reg;        // Sticky raw status
   logic [IRQ_W-1:0]   raw_next;       // Raw status next value
   logic [DAT_W-1:0]   dat_reg;        // Read data
   logic [DAT_W-1:0]   dat_next;       // Read data next value
   logic               ack_reg;        // Bus ack
   logic               irq_reg;        // Interrupt level
   logic [HOUR_W-1:0]  hour_view_reg;  // Formatted hour
   logic [HOUR_W-1:0]  hour_view_next; // Formatted hour next value
   logic [IRQ_W-1:0]   evt_s1_reg;     // Event sync, first stage
   logic [IRQ_W-1:0]   evt_s2_reg;     // Event sync, second stage
   logic [IRQ_W-1:0]   evt_s3_reg;     // Edge history
   logic [ARM_N-1:0]   evt_arm_reg;    // Edge detect armed after reset
   logic [HOUR_W-1:0]  hour_s1_reg;    // Hour sync, first stage
   logic [HOUR_W-1:0]  hour_s2_reg;    // Hour sync, second stage
   logic [HOUR_W-1:0]  hour_s3_reg;    // Hour sync, settle compare
   logic [IRQ_W-1:0]   evt;            // One-cycle event pulses
   logic               access;         // Request taken this cycle
   logic               wr;             // Write taken this cycle
   logic               rd;             // Read taken this cycle
   logic [DAT_W-1:0]   wmask;          // Byte lane write mask
   logic [DAT_W-1:0]   wdat;           // Masked write data
   logic [IRQ_W-1:0]   clr;            // Clear strobes
   logic [IRQ_W-1:0]   rd_clr;         // Clear by status read

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Take a request once; ack follows on the next edge
   assign access = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
   assign wr     = access & wb_req_i.we;
   assign rd     = access & ~wb_req_i.we;

   // Expand byte enables to a bit mask
   always_comb
   begin
      wmask = DAT_ZERO;
      for (int i = 0; i < SEL_W; i++)
      begin
         wmask[i*LANE_W +: LANE_W] = {LANE_W{wb_req_i.sel[i]}};
      end
   end

   assign wdat = wb_req_i.dat & wmask;

   // Bus ack, one cycle per request
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         ack_reg <= 1'b0;
      else
         ack_reg <= access;
   end

   // ------------------------------------------------------------
   // Alarm load registers and launch toggles
   // ------------------------------------------------------------
   // Store written lanes; any write toggles its launch line
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         alarm_reg.min  <= MIN_RST;
         alarm_reg.hour <= HOUR_RST;
         alarm_reg.day  <= DAY_RST;
         load_tgl_reg   <= '0;
      end
      else if (wr)
      begin
         unique case (wb_req_i.adr)
            OFF_MIN_ALM_LOAD:
            begin
               alarm_reg.min <= (alarm_reg.min & ~wmask[MIN_W-1:0])
                              | wdat[MIN_W-1:0];
               load_tgl_reg[LD_MIN] <= ~load_tgl_reg[LD_MIN];
            end
            OFF_HOUR_ALM_LOAD:
            begin
               alarm_reg.hour <= (alarm_reg.hour & ~wmask[HOUR_W-1:0])
                               | wdat[HOUR_W-1:0];
               load_tgl_reg[LD_HOUR] <= ~load_tgl_reg[LD_HOUR];
            end
            OFF_DAY_ALM_LOAD:
            begin
               alarm_reg.day <= (alarm_reg.day & ~wmask[DAY_W-1:0])
                              | wdat[DAY_W-1:0];
               load_tgl_reg[LD_DAY] <= ~load_tgl_reg[LD_DAY];
            end
            default:
            begin
               // Other addresses leave the loads alone
            end
         endcase
      end
   end

   // Values stay stable long after a toggle, so aon samples safely
   assign alarm_load_o = alarm_reg;
   assign load_tgl_o   = load_tgl_reg;

   // ------------------------------------------------------------
   // Enable register
   // ------------------------------------------------------------
   // Read-write enables; reserved bit 6 never stores
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         en_reg <= IRQ_RST;
      else if (wr && wb_req_i.adr == OFF_IRQ_ENABLE)
         en_reg <= ((en_reg & ~wmask[IRQ_W-1:0])
                   | wdat[IRQ_W-1:0]) & EN_RW_MASK;
   end

   // ------------------------------------------------------------
   // Event synchronisers
   // ------------------------------------------------------------
   // Toggles from the always-on domain, two flops then edge
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         evt_s1_reg <= IRQ_RST;
         evt_s2_reg <= IRQ_RST;
         evt_s3_reg <= IRQ_RST;
         evt_arm_reg <= '0;
      end
      else
      begin
         evt_s1_reg <= aon_evt_tgl_i;
         evt_s2_reg <= evt_s1_reg;
         evt_s3_reg <= evt_s2_reg;
         evt_arm_reg <= {evt_arm_reg[ARM_N-2:0], 1'b1};
      end
   end

   // Reserved position 6 can never raise an event
   // Edges masked until the sync stages hold real input,
   // so a toggle line left high across reset is no event
   assign evt = (evt_s2_reg ^ evt_s3_reg) & RAW_MASK
              & {IRQ_W{evt_arm_reg[ARM_N-1]}};

   // ------------------------------------------------------------
   // Raw status
   // ------------------------------------------------------------
   // Write-one clear on defined clear bits only
   assign clr = (wr && wb_req_i.adr == OFF_IRQ_CLEAR)
              ? (wdat[IRQ_W-1:0] & CLR_MASK) : IRQ_RST;

   // A status read clears exactly what it returned
   assign rd_clr = (rd && wb_req_i.adr == OFF_IRQ_RAW) ? raw_reg : IRQ_RST;

   // Sticky bits; a new event wins over a clear
   assign raw_next = (raw_reg & ~clr & ~rd_clr) | evt;

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         raw_reg <= IRQ_RST;
      else
         raw_reg <= raw_next;
   end

   // ------------------------------------------------------------
   // Interrupt output
   // ------------------------------------------------------------
   // Any enabled pending source except format bit 5 raises the level, also for wake
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(raw_reg & en_reg & ~FMT_ONLY);
   end

   // ------------------------------------------------------------
   // Hour format
   // ------------------------------------------------------------
   // Hour count crosses from aon; it moves once an hour
   // Third stage lets the view wait until all bits agree
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hour_s1_reg <= HOUR_RST;
         hour_s2_reg <= HOUR_RST;
         hour_s3_reg <= HOUR_RST;
      end
      else
      begin
         hour_s1_reg <= aon_hour_i;
         hour_s2_reg <= hour_s1_reg;
         hour_s3_reg <= hour_s2_reg;
      end
   end

   // 24h passes through; 12h folds and flags PM
   always_comb
   begin
      hour_view_next = hour_s2_reg;
      if (en_reg[BIT_HOUR_FMT])
      begin
         if (hour_s2_reg >= HOURS_HALF)
         begin
            hour_view_next         = hour_s2_reg - HOURS_HALF;
            hour_view_next[BIT_PM] = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         hour_view_reg <= HOUR_RST;
      else if (hour_s2_reg == hour_s3_reg) // Settled hour only
         hour_view_reg <= hour_view_next;
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Loads return stored values; clear and unmapped read zero
   always_comb
   begin
      dat_next = DAT_ZERO;
      unique case (wb_req_i.adr)
         OFF_MIN_ALM_LOAD:  dat_next[MIN_W-1:0]  = alarm_reg.min;
         OFF_HOUR_ALM_LOAD: dat_next[HOUR_W-1:0] = alarm_reg.hour;
         OFF_DAY_ALM_LOAD:  dat_next[DAY_W-1:0]  = alarm_reg.day;
         OFF_IRQ_ENABLE:    dat_next[IRQ_W-1:0]  = en_reg;
         OFF_IRQ_RAW:       dat_next[IRQ_W-1:0]  = raw_reg;
         default:           dat_next             = DAT_ZERO;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         dat_reg <= DAT_ZERO;
      else if (rd)
         dat_reg <= dat_next;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_dat_o    = dat_reg;
   assign wb_ack_o    = ack_reg;
   assign irq_o       = irq_reg;
   assign hour_view_o = hour_view_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   // Write taken at a given offset
   sequence s_write(logic [ADR_W-1:0] off);
      wr && wb_req_i.adr == off;
   endsequence

   // Read taken at a given offset
   sequence s_read(logic [ADR_W-1:0] off);
      rd && wb_req_i.adr == off;
   endsequence

   chk_ack_single_pulse: assert property (ack_reg |=> !ack_reg)
      else $error("ack held longer than one cycle");

   chk_min_load_launch: assert property (
      s_write(OFF_MIN_ALM_LOAD) |=> load_tgl_o[LD_MIN] != $past(load_tgl_o[LD_MIN]))
      else $error("minute alarm write did not launch");

   chk_hour_load_launch: assert property (
      s_write(OFF_HOUR_ALM_LOAD) |=> $changed(load_tgl_o[LD_HOUR]) && wb_ack_o)
      else $error("hour alarm write did not launch");

   chk_day_load_launch: assert property (
      s_write(OFF_DAY_ALM_LOAD) ##1 !wr [*2] |=> $stable(load_tgl_o[LD_DAY]))
      else $error("day alarm launch toggled without a write");

   chk_load_readback: assert property (
      s_write(OFF_MIN_ALM_LOAD) ##1 (!wr) [*2] ##1 s_read(OFF_MIN_ALM_LOAD)
      |=> wb_dat_o[MIN_W-1:0] == alarm_load_o.min && wb_ack_o)
      else $error("minute alarm load readback wrong");

   chk_enable_reserved: assert property (
      s_read(OFF_IRQ_ENABLE) |=> wb_dat_o[BIT_RSV] == 1'b0
                                  && wb_dat_o[DAT_W-1:IRQ_W] == '0)
      else $error("reserved enable bits read nonzero");

   chk_event_sets_raw: assert property (
      evt != '0 |=> (raw_reg & $past(evt)) == $past(evt))
      else $error("event lost against a clear");

   chk_clear_effect: assert property (
      s_write(OFF_IRQ_CLEAR) && evt == '0
      |=> (raw_reg & $past(wdat[IRQ_W-1:0] & CLR_MASK)) == '0)
      else $error("write one did not clear pending bit");

   chk_irq_level: assert property (
      (|(raw_reg & en_reg & ~FMT_ONLY)) [*2] |-> irq_o)
      else $error("interrupt low with enabled pending source");

   chk_irq_quiet: assert property (
      ((raw_reg & en_reg & ~FMT_ONLY) == '0) [*2] |-> !irq_o)
      else $error("interrupt high with nothing pending");

   chk_hour_pm_fold: assert property (
      en_reg[BIT_HOUR_FMT] && hour_s2_reg >= HOURS_HALF && hour_s2_reg == hour_s3_reg
      |=> hour_view_o[BIT_PM] && hour_view_o[BIT_PM-1:0] == $past(hour_s2_reg - HOURS_HALF))
      else $error("12 hour fold wrong");

   chk_hour_24_pass: assert property (
      !en_reg[BIT_HOUR_FMT] && hour_s2_reg == hour_s3_reg
      |=> hour_view_o == $past(hour_s2_reg))
      else $error("24 hour view altered");

   // Morning hours pass unchanged in 12 hour view
   chk_hour_am_keep: assert property (
      en_reg[BIT_HOUR_FMT] && hour_s2_reg < HOURS_HALF && hour_s2_reg == hour_s3_reg
      |=> hour_view_o == $past(hour_s2_reg))
      else $error("12 hour morning view altered");

   // Zero bits of a clear write leave pending bits alone
   chk_clear_keeps_rest: assert property (
      s_write(OFF_IRQ_CLEAR)
      |=> ($past(raw_reg) & ~($past(wdat[IRQ_W-1:0]) & CLR_MASK) & ~raw_reg) == '0)
      else $error("clear write dropped a bit written as zero");

   // A status read with no new event empties the status
   chk_raw_read_clears: assert property (
      s_read(OFF_IRQ_RAW) && evt == '0 |=> raw_reg == '0)
      else $error("status read left pending bits");

   // Every taken request is answered on the next edge
   chk_ack_after_take: assert property (
      access |=> wb_ack_o)
      else $error("request taken without ack");

endmodule

// [test/rtca_regs_tb.sv]
`timescale 1ns/1ps
module rtca_regs_tb;
   import rtca_pkg::*;

   // ------------------------------------------------------------
   // Bench signals
   // ------------------------------------------------------------
   logic                mclk_i;               // Bus clock
   logic                rst_i;                // Async reset
   rtca_wb_req_t        wb_req;               // Bus request
   logic [DAT_W-1:0]    wb_dat;               // Read data
   logic                wb_ack;               // Bus ack
   logic [IRQ_W-1:0]    evt_tgl;              // Event toggles
   logic [HOUR_W-1:0]   aon_hour;             // Hour count in
   rtca_alarm_t         alarm_load;           // Alarm values out
   logic [LOAD_N-1:0]   load_tgl;             // Launch toggles
   logic [HOUR_W-1:0]   hour_view;            // Formatted hour
   logic                irq;                  // Level interrupt
   int                  fail_count;           // Mismatches
   int                  num_checks;           // Comparisons
   logic [DAT_W-1:0]    rd;                   // Last read word
   logic [IRQ_W-1:0]    en;                   // Enable shadow
   logic [IRQ_W-1:0]    m;                    // Event mask
   logic [LOAD_N-1:0]   tgl_exp;              // Expected toggles
   logic [DAT_W-1:0]    ld_exp [LOAD_N];      // Expected load words
   logic [DAT_W-1:0]    v;                    // Random word
   int                  ch;                   // Load channel

   rtca_regs rtca_regs_inst
   (
      .mclk_i        (mclk_i),
      .rst_i         (rst_i),
      .wb_req_i      (wb_req),
      .wb_dat_o      (wb_dat),
      .wb_ack_o      (wb_ack),
      .aon_evt_tgl_i (evt_tgl),
      .aon_hour_i    (aon_hour),
      .alarm_load_o  (alarm_load),
      .load_tgl_o    (load_tgl),
      .hour_view_o   (hour_view),
      .irq_o         (irq)
   );

   // Free running bus clock, 25 ns period
   initial mclk_i = 1'b0;
   always #12.5 mclk_i = ~mclk_i;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Compare and count
   task automatic check(input string name, input logic [DAT_W-1:0] seen,
                        input logic [DAT_W-1:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         fail_count++;
      end
   endtask

   // Verdict and end of run
   task automatic summarize();
      if (fail_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // One classic cycle; holds until ack, then drops for a cycle
   task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr,
                          input logic [DAT_W-1:0] dat);
      int n;
      @(posedge mclk_i);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
      for (n = 0; n < 20; n++)
      begin
         @(posedge mclk_i);
         if (wb_ack === 1'b1)
            break;
      end
      rd = wb_dat;
      wb_req <= '0;
      if (n == 20)
      begin
         fail_count++;
         summarize();
      end
   endtask

   // Flip event toggles, then let sync and irq stages settle
   task automatic pulse(input logic [IRQ_W-1:0] msk);
      @(posedge mclk_i);
      evt_tgl <= evt_tgl ^ msk;
      repeat (6) @(posedge mclk_i);
   endtask

   function automatic logic [ADR_W-1:0] ld_off(input int c);
      return OFF_MIN_ALM_LOAD + ADR_W'(4 * c);
   endfunction

   function automatic logic [DAT_W-1:0] ld_mask(input int c);
      return (c == 0) ? 32'h0000_003F : (c == 1) ? 32'h0000_001F : 32'h0000_FFFF;
   endfunction

   function automatic logic [DAT_W-1:0] ld_field(input int c);
      return (c == 0) ? DAT_W'(alarm_load.min) : (c == 1) ? DAT_W'(alarm_load.hour)
                      : DAT_W'(alarm_load.day);
   endfunction

   // Expected hour in 24h or 12h view
   function automatic logic [HOUR_W-1:0] exp_hour(input int h, input int f);
      if (f == 0 || h < 12)
         return HOUR_W'(h);
      return HOUR_W'(h - 12) | 5'h10;
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst_i <= 1'b1;
      wb_req <= '0;
      evt_tgl <= '0;
      aon_hour <= '0;
      fail_count = 0;
      num_checks = 0;
      tgl_exp = '0;
      ld_exp = '{default: '0};
      void'($urandom(32'h3a1d));
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      // Reset values, unmapped neighbours included
      for (int a = 8'h20; a <= 8'h40; a += 4)
      begin
         wb_xfer(1'b0, ADR_W'(a), DAT_ZERO);
         check("reset read", rd, DAT_ZERO);
      end
      check("alarm reset", DAT_W'(alarm_load), DAT_ZERO);
      // Load writes: all ones first, then random channels back to back
      for (int i = 0; i < 12; i++)
      begin
         ch = (i < 3) ? i : (i == 11) ? LD_MIN : int'($urandom_range(2, 0));
         v = (i < 3) ? 32'hFFFF_FFFF : $urandom();
         ld_exp[ch] = v & ld_mask(ch);
         tgl_exp[ch] = ~tgl_exp[ch];
         wb_xfer(1'b1, ld_off(ch), v);
         check("launch toggles", DAT_W'(load_tgl), DAT_W'(tgl_exp));
         check("alarm value", ld_field(ch), ld_exp[ch]);
      end
      for (int c = 0; c < LOAD_N; c++)
      begin
         wb_xfer(1'b0, ld_off(c), DAT_ZERO);
         check("load readback", rd, ld_exp[c]);
      end
      // Enable reserved bits, write-only clear, read-only raw
      wb_xfer(1'b1, OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
      wb_xfer(1'b0, OFF_IRQ_ENABLE, DAT_ZERO);
      check("enable ones", rd, 32'h0000_FFBF);
      wb_xfer(1'b0, OFF_IRQ_CLEAR, DAT_ZERO);
      check("clear reads zero", rd, DAT_ZERO);
      wb_xfer(1'b1, OFF_IRQ_RAW, 32'hFFFF_FFFF);
      wb_xfer(1'b0, OFF_IRQ_RAW, DAT_ZERO);
      check("raw not writable", rd, DAT_ZERO);
      // Each event bit with a random enable mix
      for (int b = 0; b < IRQ_W; b++)
      begin
         en = IRQ_W'($urandom()) & EN_RW_MASK;
         m = IRQ_W'(1) << b;
         wb_xfer(1'b1, OFF_IRQ_ENABLE, DAT_W'(en));
         pulse(m);
         check("irq level", DAT_W'(irq), DAT_W'(|(en & ~FMT_ONLY & RAW_MASK & m)));
         wb_xfer(1'b1, OFF_IRQ_CLEAR, DAT_ZERO);
         wb_xfer(1'b0, OFF_IRQ_RAW, DAT_ZERO);
         check("raw sticky", rd, DAT_W'(m & RAW_MASK));
         pulse(m);
         wb_xfer(1'b1, OFF_IRQ_CLEAR, 32'hFFFF_FFFF);
         wb_xfer(1'b0, OFF_IRQ_RAW, DAT_ZERO);
         check("raw after clear", rd, DAT_W'(m & 16'h0020));
         repeat (2) @(posedge mclk_i);
         check("irq after clear", DAT_W'(irq), DAT_ZERO);
      end
      // Several events at once
      m = IRQ_W'($urandom());
      pulse(m);
      wb_xfer(1'b0, OFF_IRQ_RAW, DAT_ZERO);
      check("raw multi", rd, DAT_W'(m & RAW_MASK));
      // Event lands on the same edge as its clear
      @(posedge mclk_i);
      evt_tgl <= evt_tgl ^ 16'h0001;
      @(posedge mclk_i);
      wb_xfer(1'b1, OFF_IRQ_CLEAR, 32'h0000_0001);
      wb_xfer(1'b0, OFF_IRQ_RAW, DAT_ZERO);
      check("event beats clear", rd, 32'h0000_0001);
      // Hour view in both formats
      for (int h = 0; h < 24; h++)
         for (int f = 0; f < 2; f++)
         begin
            aon_hour <= HOUR_W'(h);
            wb_xfer(1'b1, OFF_IRQ_ENABLE, DAT_W'(f) << BIT_HOUR_FMT);
            repeat (6) @(posedge mclk_i);
            check("hour view", DAT_W'(hour_view), DAT_W'(exp_hour(h, f)));
         end
      // Second reset in mid-run wipes the load registers
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (int c = 0; c < LOAD_N; c++)
      begin
         wb_xfer(1'b0, ld_off(c), DAT_ZERO);
         check("load after reset", rd, DAT_ZERO);
      end
      // Toggle lines left high across reset raise no event
      wb_xfer(1'b0, OFF_IRQ_RAW, DAT_ZERO);
      check("raw after reset", rd, DAT_ZERO);
      summarize();
   end
endmodule
